// >>> bmc_pkg.sv
// Purpose: Shared constants for the bus and memory configuration register bank
// Assumes: Byte-wide index/data access clocked by the system clock
// Notes:   Field positions are given as least significant bit only; widths are set where each field is used
package bmc_pkg;

  // Register indexes
  localparam logic [7:0] IDX_REV   = 8'h00;
  localparam logic [7:0] IDX_MODE  = 8'h01;
  localparam logic [7:0] IDX_WAIT1 = 8'h02;
  localparam logic [7:0] IDX_WAIT2 = 8'h03;
  localparam logic [7:0] IDX_MEM1  = 8'h04;
  localparam logic [7:0] IDX_MEM2  = 8'h05;
  localparam logic [7:0] IDX_DBUF  = 8'h06;
  localparam logic [7:0] IDX_LCD   = 8'h07;
  localparam int         NUM_REGS  = 8;

  // Reset values of the stored bits
  localparam logic [7:0] RST_REV   = 8'h00;
  localparam logic [7:0] RST_MODE  = 8'h42;
  localparam logic [7:0] RST_WAIT1 = 8'hd4;
  localparam logic [7:0] RST_WAIT2 = 8'hee;
  localparam logic [7:0] RST_MEM1  = 8'h70;
  localparam logic [7:0] RST_MEM2  = 8'h20;
  localparam logic [7:0] RST_DBUF  = 8'h00;
  localparam logic [7:0] RST_LCD   = 8'h00;

  // Writable bits; the rest are reserved or read-only
  localparam logic [7:0] WM_REV    = 8'h00;
  localparam logic [7:0] WM_FULL   = 8'hff;
  localparam logic [7:0] WM_WAIT2  = 8'hef;
  localparam logic [7:0] WM_MEM2   = 8'hbb;
  localparam logic [7:0] WM_LCD    = 8'he0;

  // Bus cycle clock mode fields
  localparam int PCLK_LSB = 5;
  localparam int RANGE_B  = 4;
  localparam int LATCH_B  = 3;
  localparam int QUIET_B  = 2;
  localparam int BCLK_LSB = 0;
  // Wait-state fields
  localparam int ROMT_LSB = 6;
  localparam int RAMT_LSB = 4;
  localparam int IOT_LSB  = 2;
  localparam int EXPT_LSB = 0;
  localparam int PCA_LSB  = 5;
  localparam int PCB_LSB  = 1;
  localparam int IODLY_B  = 0;
  // Memory control fields
  localparam int PGMAP_B  = 7;
  localparam int BANK_LSB = 4;
  localparam int RTYP_LSB = 0;
  localparam int RAMW8_B  = 7;
  localparam int BOOTW_B  = 6;
  localparam int OPTW_B   = 5;
  localparam int SLOWR_B  = 4;
  localparam int SELFR_B  = 3;
  localparam int ROMEN_B  = 1;
  localparam int EARLY_B  = 0;
  // Display buffer and LCD fields
  localparam int ALTEN_B  = 7;
  localparam int OFS_LSB  = 0;
  localparam int LCDOFF_B = 7;
  localparam int VSPD_LSB = 5;

  // Divider ratios and codes
  localparam logic [3:0] PDIV_2 = 4'h2;
  localparam logic [3:0] PDIV_3 = 4'h3;
  localparam logic [3:0] PDIV_4 = 4'h4;
  localparam logic [3:0] PDIV_6 = 4'h6;
  localparam logic [3:0] PDIV_8 = 4'h8;
  localparam logic [2:0] BDIV_1 = 3'h1;
  localparam logic [2:0] BDIV_2 = 3'h2;
  localparam logic [2:0] BDIV_3 = 3'h3;
  localparam logic [2:0] BDIV_4 = 3'h4;
  localparam logic [3:0] RTYP_DRAM_LO = 4'h6;
  localparam logic [3:0] RTYP_LAST    = 4'ha;
  localparam logic [6:0] DBUF_TOP     = 7'h7f;
  localparam logic [2:0] VCLK_FAST    = 3'h3;
  localparam logic [2:0] VCLK_NORM    = 3'h4;
  localparam logic [2:0] VCLK_SLOW    = 3'h5;
  localparam logic [2:0] VCLK_WIDE    = 3'h1;

  // Complete state of the block
  typedef struct packed {
    logic [7:0]                index;
    logic [NUM_REGS-1:0][7:0]  cfg;
    logic                      strap_s1;
    logic                      strap_s2;
    logic [7:0]                rdata;
    logic                      rvalid;
    logic [3:0]                pdiv;
    logic [2:0]                bdiv;
    logic [3:0]                banks;
    logic [2:0]                vclk;
    logic [6:0]                lcd_base;
    logic                      cbr_en;
    logic                      slow_ref;
  } bmc_state_t;

endpackage

// >>> bmc_config_regs.sv
// Purpose: Indexed bus, clock, wait-state, memory and LCD configuration registers
// Assumes: Index and data strobes come from logic on ref_clk; the strap is a pin
// Notes:   Notes on behaviour and the hand-off decodes are listed below
`timescale 1ns/100ps

module bmc_config_regs
  import bmc_pkg::*;
#(
  parameter logic [7:0] REVISION = 8'h01  // Arbitrary value
) (
  // Clock, reset and enable
  input  wire logic       ref_clk,
  input  wire logic       reset_n,
  input  wire logic       clk_en,
  // Index and data access
  input  wire logic       index_wr,
  input  wire logic       data_wr,
  input  wire logic       data_rd,
  input  wire logic [7:0] wdata,
  output logic      [7:0] rdata,
  output logic            rdata_valid,
  // Board and power state
  input  wire logic       boot_rom_width_strap,
  input  wire logic       suspend_active,
  // Clock generator
  output logic      [3:0] proc_clock_divider,
  output logic      [2:0] bus_clock_divider,
  output logic            clock_range_select,
  // Bus cycle generator
  output logic            upper_address_latch,
  output logic            ext_bus_quiet,
  output logic      [1:0] rom_wait_count,
  output logic      [1:0] ram_wait_count,
  output logic      [1:0] io_wait_count,
  output logic      [1:0] expansion_wait_count,
  output logic      [2:0] card_slot_a_wait,
  output logic      [2:0] card_slot_b_wait,
  output logic            card_io_command_delay,
  // Memory controller
  output logic            page_mapping_enable,
  output logic      [3:0] ram_bank_count,
  output logic      [3:0] ram_device_type,
  output logic            ram_is_dram,
  output logic            ram_type_legal,
  output logic            ram_width_select,
  output logic            boot_rom_width,
  output logic            option_rom_width,
  output logic            suspend_slow_refresh,
  output logic            self_refreshing_dram,
  output logic            cbr_refresh_enable,
  output logic            rom_output_enable_fn,
  output logic            mapper_cycle_early_start,
  // LCD refresh
  output logic            alt_display_buffer_enable,
  output logic      [6:0] display_buffer_offset,
  output logic      [6:0] lcd_refresh_base,
  output logic            lcd_controller_disable,
  output logic      [1:0] video_refresh_speed,
  output logic      [2:0] video_clocks_per_cycle
);

  bmc_state_t s;
  bmc_state_t next_s;

  // Writable-bit mask per index; reserved and read-only bits stay put
  function automatic logic [7:0] wmask(input logic [7:0] idx);
    unique case (idx)
      IDX_REV:   wmask = WM_REV;
      IDX_WAIT2: wmask = WM_WAIT2;
      IDX_MEM2:  wmask = WM_MEM2;
      IDX_LCD:   wmask = WM_LCD;
      IDX_MODE, IDX_WAIT1, IDX_MEM1, IDX_DBUF: wmask = WM_FULL;
      default:   wmask = WM_REV;
    endcase
  endfunction

  // True for indexes inside this bank
  function automatic logic in_bank(input logic [7:0] idx);
    in_bank = (idx <= IDX_LCD);
  endfunction

  // Processor clock divisor; reserved codes fall back to the slowest ratio
  function automatic logic [3:0] pdiv_of(input logic [2:0] code);
    unique case (code)
      3'h0:    pdiv_of = PDIV_2;
      3'h1:    pdiv_of = PDIV_3;
      3'h2:    pdiv_of = PDIV_4;
      3'h3:    pdiv_of = PDIV_6;
      default: pdiv_of = PDIV_8;
    endcase
  endfunction

  // Bus clock divisor relative to the processor clock
  function automatic logic [2:0] bdiv_of(input logic [1:0] code);
    unique case (code)
      2'h0: bdiv_of = BDIV_4;
      2'h1: bdiv_of = BDIV_3;
      2'h2: bdiv_of = BDIV_2;
      2'h3: bdiv_of = BDIV_1;
    endcase
  endfunction

  // Clocks per video refresh cycle; wide RAM needs one more
  function automatic logic [2:0] vclk_of(input logic [1:0] spd, input logic narrow);
    logic [2:0] base;
    unique case (spd)
      2'h1:    base = VCLK_SLOW;
      2'h2:    base = VCLK_FAST;
      default: base = VCLK_NORM;  // Reserved code runs at normal speed
    endcase
    vclk_of = narrow ? base : base + VCLK_WIDE;
  endfunction

  localparam bmc_state_t S_RST = '{
    index:    8'h00,
    cfg:      {RST_LCD, RST_DBUF, RST_MEM2, RST_MEM1,
               RST_WAIT2, RST_WAIT1, RST_MODE, RST_REV},
    strap_s1: 1'b0,
    strap_s2: 1'b0,
    rdata:    8'h00,
    rvalid:   1'b0,
    pdiv:     PDIV_4,
    bdiv:     BDIV_2,
    banks:    4'h8,
    vclk:     VCLK_NORM + VCLK_WIDE,
    lcd_base: DBUF_TOP,
    cbr_en:   1'b1,
    slow_ref: 1'b0
  };

  // Next state: index and data port, strap sync, registered decodes
  always_comb begin
    logic [7:0] m;
    logic [7:0] cur;
    logic [7:0] rd;
    m      = 8'h00;
    cur    = 8'h00;
    rd     = 8'h00;
    next_s = s;
    if (clk_en) begin
      // Strap crosses in from a pin through two flops
      next_s.strap_s1 = boot_rom_width_strap;
      next_s.strap_s2 = s.strap_s1;
      // A data access in the same cycle as an index write uses the old index
      if (index_wr) begin
        next_s.index = wdata;
      end
      if (data_wr && in_bank(s.index)) begin
        m   = wmask(s.index);
        cur = s.cfg[s.index[2:0]];
        next_s.cfg[s.index[2:0]] = (cur & ~m) | (wdata & m);
      end
      // Read data is captured so the answer comes from a flop
      if (data_rd) begin
        if (s.index == IDX_REV) begin
          rd = REVISION;
        end else if (in_bank(s.index)) begin
          rd = s.cfg[s.index[2:0]] & wmask(s.index);
          if (s.index == IDX_MEM2) begin
            rd[BOOTW_B] = s.strap_s2;
          end
        end
        next_s.rdata = rd;
      end
      next_s.rvalid = data_rd;
      // Decodes follow the new register values on the same edge
      next_s.pdiv  = pdiv_of(next_s.cfg[IDX_MODE][PCLK_LSB +: 3]);
      next_s.bdiv  = bdiv_of(next_s.cfg[IDX_MODE][BCLK_LSB +: 2]);
      next_s.banks = {1'b0, next_s.cfg[IDX_MEM1][BANK_LSB +: 3]} + 4'h1;
      next_s.vclk  = vclk_of(next_s.cfg[IDX_LCD][VSPD_LSB +: 2],
                             next_s.cfg[IDX_MEM2][RAMW8_B]);
      next_s.lcd_base = next_s.cfg[IDX_DBUF][ALTEN_B] ?
                        next_s.cfg[IDX_DBUF][OFS_LSB +: 7] : DBUF_TOP;
      // Refresh controls only bite while suspended
      next_s.cbr_en   = !(suspend_active && next_s.cfg[IDX_MEM2][SELFR_B]);
      next_s.slow_ref = suspend_active && next_s.cfg[IDX_MEM2][SLOWR_B];
    end
  end

  // State register; clk_en low freezes everything
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      s <= S_RST;
    end else begin
      s <= next_s;
    end
  end

  // Access port answers
  assign rdata       = s.rdata;
  assign rdata_valid = s.rvalid;

  // Clock generator settings
  assign proc_clock_divider = s.pdiv;
  assign bus_clock_divider  = s.bdiv;
  assign clock_range_select = s.cfg[IDX_MODE][RANGE_B];

  // Bus cycle settings; the latch bit tells the address drivers when the
  // upper lines may float, which saves power when they are not wired
  assign upper_address_latch   = s.cfg[IDX_MODE][LATCH_B];
  assign ext_bus_quiet         = s.cfg[IDX_MODE][QUIET_B];
  assign rom_wait_count        = s.cfg[IDX_WAIT1][ROMT_LSB +: 2];
  assign ram_wait_count        = s.cfg[IDX_WAIT1][RAMT_LSB +: 2];
  assign io_wait_count         = s.cfg[IDX_WAIT1][IOT_LSB +: 2];
  assign expansion_wait_count  = s.cfg[IDX_WAIT1][EXPT_LSB +: 2];
  assign card_slot_a_wait      = s.cfg[IDX_WAIT2][PCA_LSB +: 3];
  assign card_slot_b_wait      = s.cfg[IDX_WAIT2][PCB_LSB +: 3];
  assign card_io_command_delay = s.cfg[IDX_WAIT2][IODLY_B];

  // Memory controller settings
  assign page_mapping_enable = s.cfg[IDX_MEM1][PGMAP_B];
  assign ram_bank_count      = s.banks;
  assign ram_device_type     = s.cfg[IDX_MEM1][RTYP_LSB +: 4];
  assign ram_type_legal      = ram_device_type <= RTYP_LAST;
  assign ram_is_dram         = ram_type_legal && ram_device_type >= RTYP_DRAM_LO;
  assign ram_width_select    = s.cfg[IDX_MEM2][RAMW8_B];
  assign option_rom_width    = s.cfg[IDX_MEM2][OPTW_B];
  assign boot_rom_width      = s.strap_s2;
  assign suspend_slow_refresh = s.cfg[IDX_MEM2][SLOWR_B];
  assign self_refreshing_dram = s.cfg[IDX_MEM2][SELFR_B];
  assign cbr_refresh_enable   = s.cbr_en;
  // Stored bit is active low; the output is high when the function is on
  assign rom_output_enable_fn     = ~s.cfg[IDX_MEM2][ROMEN_B];
  assign mapper_cycle_early_start = s.cfg[IDX_MEM2][EARLY_B];

  // LCD refresh settings
  assign alt_display_buffer_enable = s.cfg[IDX_DBUF][ALTEN_B];
  assign display_buffer_offset     = s.cfg[IDX_DBUF][OFS_LSB +: 7];
  assign lcd_refresh_base          = s.lcd_base;
  assign lcd_controller_disable    = s.cfg[IDX_LCD][LCDOFF_B];
  assign video_refresh_speed       = s.cfg[IDX_LCD][VSPD_LSB +: 2];
  assign video_clocks_per_cycle    = s.vclk;

  // Checks on the decodes and the access port
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  a_rev_read: assert property (
    clk_en && data_rd && s.index == IDX_REV |=> rdata == REVISION && rdata_valid)
    else $error("revision read wrong");

  a_proc_div: assert property (
    s.cfg[IDX_MODE][PCLK_LSB +: 3] == 3'h3 |-> proc_clock_divider == PDIV_6)
    else $error("processor divisor wrong");

  // Mode register bits reach the clock and bus outputs one edge after the write
  a_range_bit: assert property (
    clk_en && data_wr && s.index == IDX_MODE |=> clock_range_select == $past(wdata[RANGE_B]))
    else $error("clock range bit not written");

  a_latch_bit: assert property (
    clk_en && data_wr && s.index == IDX_MODE |=> upper_address_latch == $past(wdata[LATCH_B]))
    else $error("address latch bit not written");

  a_bus_div: assert property (
    clk_en && data_wr && s.index == IDX_MODE && wdata[BCLK_LSB +: 2] == 2'h0
    |=> bus_clock_divider == BDIV_4)
    else $error("bus divisor wrong");

  a_rom_wait: assert property (
    clk_en && data_wr && s.index == IDX_WAIT1
    |=> rom_wait_count == $past(wdata[ROMT_LSB +: 2]))
    else $error("rom wait not written");

  a_ram_wait: assert property (
    clk_en && data_wr && s.index == IDX_WAIT1
    |=> ram_wait_count == $past(wdata[RAMT_LSB +: 2]))
    else $error("ram wait not written");

  a_io_wait: assert property (
    clk_en && data_wr && s.index == IDX_WAIT1
    |=> io_wait_count == $past(wdata[IOT_LSB +: 2]))
    else $error("io wait not written");

  a_exp_wait: assert property (
    clk_en && data_wr && s.index == IDX_WAIT1
    |=> expansion_wait_count == $past(wdata[EXPT_LSB +: 2]))
    else $error("expansion wait not written");

  // Card slot fields sit either side of the reserved bit
  a_card_wait: assert property (
    clk_en && data_wr && s.index == IDX_WAIT2
    |=> card_slot_a_wait == $past(wdata[PCA_LSB +: 3])
        && card_slot_b_wait == $past(wdata[PCB_LSB +: 3]))
    else $error("card wait not written");

  a_io_delay: assert property (
    clk_en && data_wr && s.index == IDX_WAIT2
    |=> card_io_command_delay == $past(wdata[IODLY_B]))
    else $error("io command delay not written");

  a_map_enable: assert property (
    clk_en && data_wr && s.index == IDX_MEM1
    |=> page_mapping_enable == $past(wdata[PGMAP_B]))
    else $error("mapping enable not written");

  a_bank_count: assert property (
    clk_en && data_wr && s.index == IDX_MEM1 && wdata[BANK_LSB +: 3] == 3'h0
    |=> ram_bank_count == 4'h1)
    else $error("bank count wrong");

  // A reserved type code must not be taken for any device
  a_rsvd_type: assert property (
    clk_en && data_wr && s.index == IDX_MEM1 && wdata[RTYP_LSB +: 4] == 4'hb
    |=> !ram_type_legal && !ram_is_dram)
    else $error("reserved ram type accepted");

  a_ram_width: assert property (
    clk_en && data_wr && s.index == IDX_MEM2
    |=> ram_width_select == $past(wdata[RAMW8_B]) && option_rom_width == $past(wdata[OPTW_B]))
    else $error("width selects not written");

  a_strap_read: assert property (
    clk_en && data_rd && s.index == IDX_MEM2 |=> rdata[BOOTW_B] == $past(boot_rom_width))
    else $error("strap bit read wrong");

  // Refresh gating uses the register value written on the same edge
  a_self_ref: assert property (
    clk_en |=> cbr_refresh_enable == !($past(suspend_active) && self_refreshing_dram))
    else $error("cbr refresh gating wrong");

  a_slow_ref: assert property (
    clk_en |=> s.slow_ref == ($past(suspend_active) && suspend_slow_refresh))
    else $error("slow refresh gating wrong");

  a_rom_oe: assert property (
    clk_en && data_wr && s.index == IDX_MEM2
    |=> rom_output_enable_fn == !$past(wdata[ROMEN_B]))
    else $error("rom output enable polarity wrong");

  a_early_map: assert property (
    clk_en && data_wr && s.index == IDX_MEM2
    |=> mapper_cycle_early_start == $past(wdata[EARLY_B]))
    else $error("mapper start bit not written");

  a_lcd_base: assert property (
    !alt_display_buffer_enable |-> lcd_refresh_base == DBUF_TOP)
    else $error("lcd base not top");

  a_alt_base: assert property (
    alt_display_buffer_enable |-> lcd_refresh_base == display_buffer_offset)
    else $error("lcd base not offset");

  a_lcd_off: assert property (
    clk_en && data_wr && s.index == IDX_LCD
    |=> lcd_controller_disable == $past(wdata[LCDOFF_B])
        && video_refresh_speed == $past(wdata[VSPD_LSB +: 2]))
    else $error("lcd control not written");

  a_rsvd_zero: assert property (
    clk_en && data_rd && s.index == IDX_LCD |=> rdata[4:0] == 5'h00)
    else $error("reserved bits not zero");

  a_rsvd_hold: assert property (
    clk_en && data_wr && s.index == IDX_WAIT2
    |=> s.cfg[IDX_WAIT2][4] == $past(s.cfg[IDX_WAIT2][4]))
    else $error("reserved bit written");

  c_mode_write: cover property (clk_en && index_wr ##1 clk_en && data_wr && s.index == IDX_MODE);
  c_alt_buffer: cover property (alt_display_buffer_enable && lcd_refresh_base != DBUF_TOP);
  c_suspend:    cover property (suspend_active && !cbr_refresh_enable);
  c_strap_read: cover property (clk_en && data_rd && s.index == IDX_MEM2 ##1 rdata[BOOTW_B]);

endmodule // bmc_config_regs

// >>> bmc_config_regs_tb.sv
// Purpose: Self-checking bench for the bus and memory configuration register bank
// Assumes: Inputs change on the falling edge; reads are scored by a separate monitor
// Notes:   A shadow copy of every register drives the expected values, apart from the revision, strap and suspend terms
`timescale 1ns/100ps

`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin num_errors++; \
  $display("Error %s expected %h seen %h", nm, ex, got); end end

module bmc_config_regs_tb;
  import bmc_pkg::*;

  localparam logic [7:0] REV_VAL = 8'h5a;  // Arbitrary value

  // Stimulus and bookkeeping
  logic       ref_clk = 1'b0, reset_n = 1'b0, clk_en = 1'b1;
  logic       index_wr = 1'b0, data_wr = 1'b0, data_rd = 1'b0;
  logic       boot_rom_width_strap = 1'b0, suspend_active = 1'b0;
  logic [7:0] wdata = 8'h00, rdata, v, e;
  logic [7:0] sh [8];
  logic [7:0] exp_q [$];
  int         num_errors = 0, total_checks = 0, seed = 32'hf3bb;
  // Decoded outputs
  logic       rdata_valid, clock_range_select, upper_address_latch, ext_bus_quiet;
  logic       card_io_command_delay, page_mapping_enable, ram_is_dram, ram_type_legal;
  logic       ram_width_select, boot_rom_width, option_rom_width, suspend_slow_refresh;
  logic       self_refreshing_dram, cbr_refresh_enable, rom_output_enable_fn;
  logic       mapper_cycle_early_start, alt_display_buffer_enable, lcd_controller_disable;
  logic [3:0] proc_clock_divider, ram_bank_count, ram_device_type;
  logic [2:0] bus_clock_divider, card_slot_a_wait, card_slot_b_wait, video_clocks_per_cycle;
  logic [1:0] rom_wait_count, ram_wait_count, io_wait_count, expansion_wait_count;
  logic [1:0] video_refresh_speed;
  logic [6:0] display_buffer_offset, lcd_refresh_base;
  // Expected decode tables
  logic [3:0] pd   [8] = '{4'h2, 4'h3, 4'h4, 4'h6, 4'h8, 4'h8, 4'h8, 4'h8};
  logic [2:0] bd   [4] = '{3'h4, 3'h3, 3'h2, 3'h1};
  logic [2:0] vc8  [4] = '{3'h4, 3'h5, 3'h3, 3'h4};
  logic [2:0] vc16 [4] = '{3'h5, 3'h6, 3'h4, 3'h5};
  logic [7:0] wm   [8] = '{8'h00, 8'hff, 8'hff, 8'hef, 8'hff, 8'hbb, 8'hff, 8'he0};

  bmc_config_regs #(.REVISION(REV_VAL)) i_dut (
    .ref_clk(ref_clk), .reset_n(reset_n), .clk_en(clk_en), .index_wr(index_wr),
    .data_wr(data_wr), .data_rd(data_rd), .wdata(wdata), .rdata(rdata),
    .rdata_valid(rdata_valid), .boot_rom_width_strap(boot_rom_width_strap),
    .suspend_active(suspend_active), .proc_clock_divider(proc_clock_divider),
    .bus_clock_divider(bus_clock_divider), .clock_range_select(clock_range_select),
    .upper_address_latch(upper_address_latch), .ext_bus_quiet(ext_bus_quiet),
    .rom_wait_count(rom_wait_count), .ram_wait_count(ram_wait_count),
    .io_wait_count(io_wait_count), .expansion_wait_count(expansion_wait_count),
    .card_slot_a_wait(card_slot_a_wait), .card_slot_b_wait(card_slot_b_wait),
    .card_io_command_delay(card_io_command_delay), .page_mapping_enable(page_mapping_enable),
    .ram_bank_count(ram_bank_count), .ram_device_type(ram_device_type),
    .ram_is_dram(ram_is_dram), .ram_type_legal(ram_type_legal),
    .ram_width_select(ram_width_select), .boot_rom_width(boot_rom_width),
    .option_rom_width(option_rom_width), .suspend_slow_refresh(suspend_slow_refresh),
    .self_refreshing_dram(self_refreshing_dram), .cbr_refresh_enable(cbr_refresh_enable),
    .rom_output_enable_fn(rom_output_enable_fn),
    .mapper_cycle_early_start(mapper_cycle_early_start),
    .alt_display_buffer_enable(alt_display_buffer_enable),
    .display_buffer_offset(display_buffer_offset), .lcd_refresh_base(lcd_refresh_base),
    .lcd_controller_disable(lcd_controller_disable),
    .video_refresh_speed(video_refresh_speed), .video_clocks_per_cycle(video_clocks_per_cycle)
  );

  // 50 MHz clock
  always #10 ref_clk = ~ref_clk;

  // Verdict and end of run
  task automatic finish_test();
    $display("Checks %0d, errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Reset for two cycles, shadow back to documented reset values
  task automatic do_reset();
    reset_n = 1'b0;
    repeat (2) @(negedge ref_clk);
    reset_n = 1'b1;
    sh = '{8'h00, 8'h42, 8'hd4, 8'hee, 8'h70, 8'h20, 8'h00, 8'h00};
  endtask

  // Index cycle followed by a data write; index and data are separate strobes
  task automatic wreg(input logic [7:0] idx, input logic [7:0] val);
    @(negedge ref_clk) index_wr = 1'b1;
    wdata = idx;
    @(negedge ref_clk) index_wr = 1'b0;
    data_wr = 1'b1;
    wdata = val;
    @(negedge ref_clk) data_wr = 1'b0;
  endtask

  // Index cycle followed by a read; the expected byte goes to the monitor queue
  task automatic rreg(input logic [7:0] idx);
    @(negedge ref_clk) index_wr = 1'b1;
    wdata = idx;
    @(negedge ref_clk) index_wr = 1'b0;
    data_rd = 1'b1;
    if (idx == 8'h00) exp_q.push_back(REV_VAL);
    else if (idx > 8'h07) exp_q.push_back(8'h00);
    else if (idx == 8'h05) exp_q.push_back(sh[5] | {1'b0, boot_rom_width_strap, 6'h00});
    else exp_q.push_back(sh[idx[2:0]]);
    @(negedge ref_clk) data_rd = 1'b0;
  endtask

  // Every decoded output against the shadow registers
  task automatic check_outs();
    `CHK("proc_clock_divider", pd[sh[1][7:5]], proc_clock_divider)
    `CHK("clock_range_select", sh[1][4], clock_range_select)
    `CHK("upper_address_latch", sh[1][3], upper_address_latch)
    `CHK("ext_bus_quiet", sh[1][2], ext_bus_quiet)
    `CHK("bus_clock_divider", bd[sh[1][1:0]], bus_clock_divider)
    `CHK("rom_wait_count", sh[2][7:6], rom_wait_count)
    `CHK("ram_wait_count", sh[2][5:4], ram_wait_count)
    `CHK("io_wait_count", sh[2][3:2], io_wait_count)
    `CHK("expansion_wait_count", sh[2][1:0], expansion_wait_count)
    `CHK("card_waits", {sh[3][7:5], sh[3][3:1]}, {card_slot_a_wait, card_slot_b_wait})
    `CHK("card_io_command_delay", sh[3][0], card_io_command_delay)
    `CHK("page_mapping_enable", sh[4][7], page_mapping_enable)
    `CHK("ram_bank_count", {1'b0, sh[4][6:4]} + 4'h1, ram_bank_count)
    `CHK("ram_device_type", sh[4][3:0], ram_device_type)
    `CHK("ram_type_legal", sh[4][3:0] <= 4'ha, ram_type_legal)
    `CHK("ram_is_dram", sh[4][3:0] >= 4'h6 && sh[4][3:0] <= 4'ha, ram_is_dram)
    `CHK("rom_widths", {sh[5][7], sh[5][5]}, {ram_width_select, option_rom_width})
    `CHK("boot_rom_width", boot_rom_width_strap, boot_rom_width)
    `CHK("refresh_bits", sh[5][4:3], {suspend_slow_refresh, self_refreshing_dram})
    `CHK("cbr_refresh_enable", ~(suspend_active & sh[5][3]), cbr_refresh_enable)
    `CHK("rom_output_enable_fn", ~sh[5][1], rom_output_enable_fn)
    `CHK("mapper_cycle_early_start", sh[5][0], mapper_cycle_early_start)
    `CHK("lcd_refresh_base", sh[6][7] ? sh[6][6:0] : 7'h7f, lcd_refresh_base)
    `CHK("alt_display_buffer_enable", sh[6][7], alt_display_buffer_enable)
    `CHK("display_buffer_offset", sh[6][6:0], display_buffer_offset)
    `CHK("lcd_controller_disable", sh[7][7], lcd_controller_disable)
    `CHK("video_refresh_speed", sh[7][6:5], video_refresh_speed)
    `CHK("video_clocks", sh[5][7] ? vc8[sh[7][6:5]] : vc16[sh[7][6:5]],
         video_clocks_per_cycle)
  endtask

  // Read back every index, one unmapped, after letting outputs settle
  task automatic sweep();
    repeat (3) @(negedge ref_clk);
    check_outs();
    for (int i = 0; i < 9; i++) rreg(i[7:0]);
  endtask

  // Monitor: each valid read pops the oldest expected byte; sampled on the
  // falling edge so the registered answer has settled
  always @(negedge ref_clk) begin
    if (rdata_valid === 1'b1) begin
      if (exp_q.size() == 0) begin
        num_errors++;
        $display("Error rdata expected none seen %h", rdata);
      end else begin
        e = exp_q.pop_front();
        `CHK("rdata", e, rdata)
      end
    end
  end

  // Hang guard
  initial begin
    repeat (20000) @(posedge ref_clk);
    num_errors++;
    $display("Error watchdog expected done seen hung");
    finish_test();
  end

  // Main sequence
  initial begin
    do_reset();
    sweep();
    // Random contents, strap and suspend; index zero writes must be dropped
    for (int r = 0; r < 12; r++) begin
      boot_rom_width_strap = $random(seed);
      suspend_active = $random(seed);
      for (int i = 0; i < 8; i++) begin
        v = $random(seed);
        if (r < 8 && i == 1) v[7:5] = r[2:0];
        if (r < 4 && i == 1) v[1:0] = r[1:0];
        if (r < 4 && i == 7) v[6:5] = r[1:0];
        wreg(i[7:0], v);
        sh[i] = (v & wm[i]) | (sh[i] & ~wm[i]);
      end
      sweep();
    end
    // Unused upper address lines: software parks the latch bit clear to save power
    wreg(8'h01, sh[1] & 8'hf7);
    sh[1] = sh[1] & 8'hf7;
    @(negedge ref_clk) `CHK("latch_parked", 1'b0, upper_address_latch)
    // Frozen clock enable drops a write
    @(negedge ref_clk) clk_en = 1'b0;
    wreg(8'h02, ~sh[2]);
    @(negedge ref_clk) clk_en = 1'b1;
    rreg(8'h02);
    // Second reset in mid-run restores every reset value; one edge first so
    // the last read answer is scored before reset clears it
    @(negedge ref_clk);
    boot_rom_width_strap = 1'b0;
    do_reset();
    sweep();
    for (int k = 0; k < 10 && exp_q.size() > 0; k++) @(negedge ref_clk);
    `CHK("pending_reads", 0, exp_q.size())
    finish_test();
  end

endmodule // bmc_config_regs_tb
